//--- src/fpb_host.v
// Host controller for an asynchronous parallel NOR flash, AXI4-Lite side
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "fpb_map.vh"

// How it works
// - Reads drive chip enable and output enable low, write enable high.
// - Command writes drive write and chip enable low, output enable high.
// - Fast program mode programs with two write cycles instead of four.
// - High voltage only during accelerated programming; pin never floats.
// - Host flags in status, but does not restart, any operation that a hardware reset interrupted.
// - Reads are valid only after the reset-to-read delay.
module fpb_host
(
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [4:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [4:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg  [20:0] flash_addr,
	input  wire [15:0] data_io_i,
	output reg  [15:0] data_io_o,
	output reg  [15:0] data_io_oe,
	output reg         chip_en_n,
	output reg         out_en_n,
	output reg         write_en_n,
	output reg         flash_reset_n,
	output reg         word_mode,
	output reg         protect_accel_pin,
	output reg         high_voltage_level,
	input  wire        ready_busy_n
);

	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_READ  = 3'h1;
	localparam [2:0] ST_WRLO  = 3'h2;
	localparam [2:0] ST_WRHI  = 3'h3;
	localparam [2:0] ST_RSTLO = 3'h4;
	localparam [2:0] ST_RSTRC = 3'h5;
	localparam [2:0] ST_WAITB = 3'h6;

	localparam [31:0] ACC_N   = `FPB_CYC_UP(`FPB_T_ACC_NS);
	localparam [31:0] WP_N    = `FPB_CYC_UP(`FPB_T_WP_NS);
	localparam [31:0] WPH_N   = `FPB_CYC_UP(`FPB_T_WPH_NS);
	localparam [31:0] RP_N    = `FPB_CYC_UP(`FPB_T_RP_NS);
	localparam [31:0] RH_N    = `FPB_CYC_UP(`FPB_T_RH_NS);
	localparam [31:0] BUSY_N  = `FPB_CYC_UP(`FPB_T_BUSY_NS);
	localparam [7:0] ACC_CYC  = ACC_N[7:0];
	localparam [7:0] WP_CYC   = WP_N[7:0];
	localparam [7:0] WPH_CYC  = WPH_N[7:0];
	localparam [7:0] RP_CYC   = RP_N[7:0];
	localparam [7:0] RH_CYC   = RH_N[7:0];
	localparam [7:0] BUSY_CYC = BUSY_N[7:0];

	reg  [3:0]  ctrl_q;
	reg  [21:0] addr_q;
	reg  [15:0] wdata_q;
	reg  [15:0] rdata_q;
	reg         refused_q;
	reg         aborted_q;
	reg  [2:0]  state_q;
	reg  [7:0]  cnt_q;
	reg  [1:0]  step_q;
	reg         prog_q;
	reg         rb_q;
	reg  [20:0] cyc_addr_d;
	reg  [15:0] cyc_data_d;
	reg  [31:0] rd_d;
	reg  [1:0]  rresp_d;

	wire        wr_go   = s_axi_awready & s_axi_wready;
	wire        rd_go   = s_axi_arready;
	wire        busy    = (state_q != ST_IDLE);
	wire        cmd_hit = wr_go & (s_axi_awaddr == `FPB_REG_CMD);
	wire [1:0]  cmd_op  = s_axi_wdata[1:0];
	wire        bytem   = ~ctrl_q[`FPB_CTRL_WORD];

	// ----------------------------------------------------------------
	// Bus cycle address and data for the current program step
	// ----------------------------------------------------------------
	always @*
	begin
		cyc_addr_d = bytem ? addr_q[21:1] : addr_q[20:0];
		cyc_data_d = wdata_q;
		if (prog_q && step_q == `FPB_STEP_FIRST)
		begin
			cyc_addr_d = `FPB_UNLOCK_A1;
			cyc_data_d = `FPB_UNLOCK_D1;
		end
		else if (prog_q && step_q == 2'h1)
		begin
			cyc_addr_d = `FPB_UNLOCK_A2;
			cyc_data_d = `FPB_UNLOCK_D2;
		end
		else if (prog_q && step_q == `FPB_STEP_FAST)
		begin
			cyc_addr_d = `FPB_PROG_A;
			cyc_data_d = `FPB_PROG_D;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite handshakes
	// ----------------------------------------------------------------
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `FPB_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= `FPB_RESP_OKAY;
			s_axi_rdata   <= 32'h0000_0000;
		end
		else
		begin
			s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~wr_go &
				~s_axi_bvalid;
			s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~wr_go &
				~s_axi_bvalid;
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (s_axi_awaddr > `FPB_REG_CMD ||
					s_axi_awaddr[1:0] != 2'b00) ? `FPB_RESP_SLVERR :
					`FPB_RESP_OKAY;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			s_axi_arready <= s_axi_arvalid & ~rd_go & ~s_axi_rvalid;
			if (rd_go)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_d;
				s_axi_rresp  <= rresp_d;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Register read decode
	// ----------------------------------------------------------------
	always @*
	begin
		rd_d    = 32'h0000_0000;
		rresp_d = `FPB_RESP_OKAY;
		if (s_axi_araddr == `FPB_REG_CTRL)
			rd_d = {28'h000_0000, ctrl_q};
		else if (s_axi_araddr == `FPB_REG_ADDR)
			rd_d = {10'h000, addr_q};
		else if (s_axi_araddr == `FPB_REG_WDATA)
			rd_d = {16'h0000, wdata_q};
		else if (s_axi_araddr == `FPB_REG_CMD)
			rd_d = 32'h0000_0000;
		else if (s_axi_araddr == `FPB_REG_STATUS)
			rd_d = {28'h000_0000, aborted_q, refused_q, rb_q, busy};
		else if (s_axi_araddr == `FPB_REG_RDATA)
			rd_d = {16'h0000, rdata_q};
		else
			rresp_d = `FPB_RESP_SLVERR;
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_q    <= `FPB_CTRL_RST;
			addr_q    <= 22'h00_0000;
			wdata_q   <= 16'h0000;
			refused_q <= 1'b0;
			rb_q      <= 1'b1;
		end
		else
		begin
			rb_q <= ready_busy_n;
			if (wr_go && !busy && s_axi_wstrb[0])
			begin
				if (s_axi_awaddr == `FPB_REG_CTRL)
					ctrl_q <= s_axi_wdata[3:0];
				else if (s_axi_awaddr == `FPB_REG_ADDR)
					addr_q <= s_axi_wdata[21:0];
				else if (s_axi_awaddr == `FPB_REG_WDATA)
					wdata_q <= s_axi_wdata[15:0];
			end
			if (wr_go && busy && s_axi_awaddr != `FPB_REG_STATUS)
				refused_q <= 1'b1;
			else if (cmd_hit)
				refused_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Flash pin sequencer
	// ----------------------------------------------------------------
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q            <= ST_IDLE;
			cnt_q              <= 8'h00;
			step_q             <= `FPB_STEP_FIRST;
			prog_q             <= 1'b0;
			rdata_q            <= 16'h0000;
			aborted_q          <= 1'b0;
			flash_addr         <= 21'h00_0000;
			data_io_o          <= 16'h0000;
			data_io_oe         <= 16'h0000;
			chip_en_n          <= 1'b1;
			out_en_n           <= 1'b1;
			write_en_n         <= 1'b1;
			flash_reset_n      <= 1'b1;
			word_mode          <= 1'b1;
			protect_accel_pin  <= 1'b0;
			high_voltage_level <= 1'b0;
		end
		else
		begin
			word_mode         <= ctrl_q[`FPB_CTRL_WORD];
			protect_accel_pin <= ctrl_q[`FPB_CTRL_WP];
			case (state_q)
			ST_IDLE:
			begin
				chip_en_n          <= 1'b1;
				out_en_n           <= 1'b1;
				write_en_n         <= 1'b1;
				data_io_oe         <= 16'h0000;
				high_voltage_level <= 1'b0;
				if (cmd_hit && !s_axi_wdata[2] && s_axi_wstrb[0])
				begin
					prog_q <= (cmd_op == `FPB_OP_PROGRAM);
					step_q <= (ctrl_q[`FPB_CTRL_FAST] ||
						ctrl_q[`FPB_CTRL_ACCEL]) ?
						`FPB_STEP_FAST : `FPB_STEP_FIRST;
					if (cmd_op == `FPB_OP_RESET)
					begin
						flash_reset_n <= 1'b0;
						cnt_q         <= RP_CYC;
						aborted_q     <= ~ready_busy_n;
						state_q       <= ST_RSTLO;
					end
					else if (cmd_op == `FPB_OP_READ)
					begin
						flash_addr <= bytem ? addr_q[21:1] :
							addr_q[20:0];
						data_io_o  <= {addr_q[0], 15'h0000};
						data_io_oe <= {bytem, 15'h0000};
						chip_en_n  <= 1'b0;
						out_en_n   <= 1'b0;
						cnt_q      <= ACC_CYC;
						state_q    <= ST_READ;
					end
					else
					begin
						high_voltage_level <= ctrl_q[`FPB_CTRL_ACCEL] &
							(cmd_op == `FPB_OP_PROGRAM);
						cnt_q   <= 8'h01;
						state_q <= ST_WRHI;
					end
				end
			end
			ST_READ:
			begin
				// Access time covers both address and select paths
				if (cnt_q == 8'h01)
				begin
					rdata_q   <= bytem ? {8'h00, data_io_i[7:0]} :
						data_io_i;
					chip_en_n <= 1'b1;
					out_en_n  <= 1'b1;
					data_io_oe <= 16'h0000;
					state_q   <= ST_IDLE;
				end
				else
					cnt_q <= cnt_q - 8'h01;
			end
			ST_WRLO:
			begin
				if (cnt_q == 8'h01)
				begin
					write_en_n <= 1'b1;
					cnt_q      <= WPH_CYC;
					state_q    <= ST_WRHI;
				end
				else
					cnt_q <= cnt_q - 8'h01;
			end
			ST_WRHI:
			begin
				// Data held through the high phase before the next cycle
				if (cnt_q != 8'h01)
					cnt_q <= cnt_q - 8'h01;
				else if (!write_en_n || chip_en_n)
				begin
					flash_addr <= cyc_addr_d;
					data_io_o  <= bytem ? {addr_q[0] & ~prog_q |
						addr_q[0] & (step_q == `FPB_STEP_LAST),
						7'h00, cyc_data_d[7:0]} : cyc_data_d;
					data_io_oe <= bytem ? 16'h80ff : 16'hffff;
					out_en_n   <= 1'b1;
					chip_en_n  <= 1'b0;
					write_en_n <= 1'b0;
					cnt_q      <= WP_CYC;
					state_q    <= ST_WRLO;
				end
				else if (prog_q && step_q != `FPB_STEP_LAST)
				begin
					step_q    <= step_q + 2'h1;
					chip_en_n <= 1'b1;
				end
				else if (prog_q)
				begin
					chip_en_n  <= 1'b1;
					data_io_oe <= 16'h0000;
					cnt_q      <= BUSY_CYC;
					state_q    <= ST_WAITB;
				end
				else
				begin
					chip_en_n <= 1'b1;
					state_q   <= ST_IDLE;
				end
			end
			ST_WAITB:
			begin
				// Hold high voltage until program finishes
				if (cnt_q != 8'h00)
					cnt_q <= cnt_q - 8'h01;
				else if (rb_q)
					state_q <= ST_IDLE;
			end
			ST_RSTLO:
			begin
				high_voltage_level <= 1'b0;
				chip_en_n          <= 1'b1;
				out_en_n           <= 1'b1;
				write_en_n         <= 1'b1;
				data_io_oe         <= 16'h0000;
				if (cnt_q == 8'h01)
				begin
					flash_reset_n <= 1'b1;
					cnt_q         <= RH_CYC;
					state_q       <= ST_RSTRC;
				end
				else
					cnt_q <= cnt_q - 8'h01;
			end
			ST_RSTRC:
			begin
				if (cnt_q != 8'h00)
					cnt_q <= cnt_q - 8'h01;
				else if (rb_q)
					state_q <= ST_IDLE;
			end
			default:
				state_q <= ST_IDLE;
			endcase
		end
	end

endmodule // fpb_host

//--- src/fpb_map.vh
// Register map, command codes and timing counts of the flash bus host
`ifndef FPB_MAP_VH
`define FPB_MAP_VH

// Register byte offsets
`define FPB_REG_CTRL      5'h00
`define FPB_REG_ADDR      5'h04
`define FPB_REG_WDATA     5'h08
`define FPB_REG_CMD       5'h0c
`define FPB_REG_STATUS    5'h10
`define FPB_REG_RDATA     5'h14

// Control fields
`define FPB_CTRL_WORD     0
`define FPB_CTRL_WP       1
`define FPB_CTRL_ACCEL    2
`define FPB_CTRL_FAST     3
`define FPB_CTRL_RST      4'h1

// Operation codes in the command register
`define FPB_OP_READ       2'h0
`define FPB_OP_WRITE      2'h1
`define FPB_OP_PROGRAM    2'h2
`define FPB_OP_RESET      2'h3

// Status fields
`define FPB_ST_BUSY       0
`define FPB_ST_RB         1
`define FPB_ST_REFUSED    2
`define FPB_ST_ABORTED    3

// Program unlock sequence
`define FPB_UNLOCK_A1     21'h000555
`define FPB_UNLOCK_D1     16'h00aa
`define FPB_UNLOCK_A2     21'h0002aa
`define FPB_UNLOCK_D2     16'h0055
`define FPB_PROG_A        21'h000555
`define FPB_PROG_D        16'h00a0
`define FPB_STEP_FIRST    2'h0
`define FPB_STEP_FAST     2'h2
`define FPB_STEP_LAST     2'h3

// Times in ns and derived cycle counts
`define FPB_CLK_NS        10
`define FPB_T_ACC_NS      90
`define FPB_T_WP_NS       35
`define FPB_T_WPH_NS      30
`define FPB_T_RP_NS       500
`define FPB_T_RH_NS       50
`define FPB_T_BUSY_NS     90
`define FPB_CYC_UP(t)     (((t) + `FPB_CLK_NS - 1) / `FPB_CLK_NS)

// AXI responses
`define FPB_RESP_OKAY     2'b00
`define FPB_RESP_SLVERR   2'b10

`endif

//--- testbench/fpb_flash_model.sv
// Behavioural flash device facing the host pins
`timescale 1ns/1ps
`include "fpb_map.vh"
module fpb_flash_model
#(
	parameter ACC   = 6,
	parameter BUSY  = 20,
	parameter ERASE = 100,
	parameter [7:0] ID_CODE = 8'h5a // Arbitrary identification code
)
(
	input  wire        aclk,
	input  wire [20:0] flash_addr,
	input  wire [15:0] data_io_o,
	input  wire [15:0] data_io_oe,
	input  wire        chip_en_n,
	input  wire        out_en_n,
	input  wire        write_en_n,
	input  wire        flash_reset_n,
	input  wire        word_mode,
	input  wire        protect_accel_pin,
	input  wire        high_voltage_level,
	output wire [15:0] data_io_i,
	output wire        ready_busy_n
);
	reg  [21:0] addr_q = 0;
	reg  [7:0]  acc_q = 0, busy_q = 0, wcnt_q = 0;
	reg         we_q = 1, prog_q = 0, tog_q = 0, id_q = 0;
	reg  [8:0]  sect_q = 0;
	reg  [7:0]  pgm_q = 0;
	wire [21:0] at = {flash_addr, data_io_o[15]};
	wire        on = !chip_en_n && !out_en_n && flash_reset_n;
	wire [15:0] av = word_mode ? flash_addr[15:0] ^ 16'ha5c3 :
		{8'h00, at[7:0] ^ 8'hc3};
	wire [15:0] dv = id_q ? {8'h00, ID_CODE} : av;
	// Top boot sectors locked while the protect pin and high voltage are both low
	wire        lock = !protect_accel_pin && !high_voltage_level &&
		(&flash_addr[20:13]);
	// Data only after the access time, else a changing pattern
	wire [15:0] md = (on && acc_q == ACC) ? dv : {16{tog_q}};
	wire [15:0] mw = word_mode ? md : {{8{tog_q}}, md[7:0]};
	assign data_io_i = (data_io_oe & data_io_o) | (~data_io_oe & mw);
	assign ready_busy_n = busy_q == 8'h00;
	always @(posedge aclk)
	begin
		tog_q  <= ~tog_q;
		we_q   <= write_en_n;
		addr_q <= at;
		acc_q  <= (!on || at != addr_q) ? 8'h00 :
			acc_q + {7'h0, acc_q != ACC};
		if (busy_q != 8'h00)
			busy_q <= busy_q - 8'h01;
		if (!flash_reset_n)
			id_q <= 1'b0;
		if (flash_reset_n && !we_q && write_en_n && !chip_en_n && ready_busy_n)
		begin
			wcnt_q <= wcnt_q + 8'h01;
			prog_q <= data_io_o == `FPB_PROG_D;
			if (prog_q && !lock)
			begin
				busy_q <= BUSY;
				pgm_q  <= pgm_q + 8'h01;
			end
			else if (!prog_q && data_io_o[7:0] == 8'h30)
			begin
				busy_q <= ERASE;
				sect_q <= flash_addr[20:12];
			end
			else if (!prog_q && data_io_o[7:0] == 8'h90)
				id_q <= 1'b1;
			else if (!prog_q && data_io_o[7:0] == 8'hf0)
				id_q <= 1'b0;
		end
	end
endmodule // fpb_flash_model

//--- testbench/fpb_host_props.sv
// Pin and bus timing checks for the flash host
`timescale 1ns/1ps
module fpb_host_props
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [15:0] data_io_oe,
	input wire logic        chip_en_n,
	input wire logic        out_en_n,
	input wire logic        write_en_n,
	input wire logic        flash_reset_n,
	input wire logic        word_mode,
	input wire logic        high_voltage_level
);
	logic [7:0] rst_cnt_q;
	// Length of the current reset pulse
	always @(posedge aclk)
	begin
		if (!aresetn || flash_reset_n)
			rst_cnt_q <= 8'h00;
		else if (rst_cnt_q != 8'hff)
			rst_cnt_q <= rst_cnt_q + 8'h01;
	end
	logic [7:0] oe_lo_q;
	// Length of the current output-enable strobe
	always @(posedge aclk)
	begin
		if (!aresetn || out_en_n)
			oe_lo_q <= 8'h00;
		else if (oe_lo_q != 8'hff)
			oe_lo_q <= oe_lo_q + 8'h01;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence we_pulse;
		!write_en_n [*4] ##1 write_en_n [*3];
	endsequence
	sequence rd_hold;
		oe_lo_q == 8'd9;
	endsequence
	rd_strobe_a: assert property (!out_en_n |-> !chip_en_n && write_en_n)
		else $error("read strobes wrong");
	wr_strobe_a: assert property (!write_en_n |-> !chip_en_n && out_en_n)
		else $error("write strobes wrong");
	byte_hiz_a: assert property (!word_mode |-> data_io_oe[14:8] == 7'h00)
		else $error("upper lines driven in byte mode");
	rd_nodrive_a: assert property (!out_en_n |-> data_io_oe[14:0] == 15'h0000 && data_io_oe[15] == !word_mode)
		else $error("host drives data during read");
	wr_pulse_a: assert property ($fell(write_en_n) |-> we_pulse)
		else $error("write pulse shape wrong");
	rd_access_a: assert property ($rose(out_en_n) |-> rd_hold)
		else $error("read access too short");
	rst_width_a: assert property ($rose(flash_reset_n) |-> rst_cnt_q == 8'd50)
		else $error("reset pulse width wrong");
	rst_quiet_a: assert property (!flash_reset_n |-> chip_en_n && out_en_n)
		else $error("access during reset pulse");
	reset_gap_a: assert property ($rose(flash_reset_n) |-> chip_en_n [*5])
		else $error("access too soon after reset");
	hv_write_a: assert property (high_voltage_level |-> out_en_n)
		else $error("high voltage during read");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
endmodule // fpb_host_props

bind fpb_host fpb_host_props chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.data_io_oe(data_io_oe), .chip_en_n(chip_en_n), .out_en_n(out_en_n),
	.write_en_n(write_en_n), .flash_reset_n(flash_reset_n),
	.word_mode(word_mode), .high_voltage_level(high_voltage_level));

//--- testbench/test_fpb_host.sv
// Self-checking bench for the flash bus host
`timescale 1ns/1ps
`include "fpb_map.vh"
module test_fpb_host;
	logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic        arvalid = 0, rready = 0;
	logic [4:0]  awaddr = 0, araddr = 0;
	logic [3:0]  wstrb = 4'hf;
	logic [31:0] wdata = 0, last_rd, rs = 90;
	logic [65:0] e, rq[$];
	logic [1:0]  bq[$];
	int          n_fail = 0, checked = 0;
	wire         awready, wready, bvalid, arready, rvalid, ce_n, oe_n, we_n;
	wire         frst_n, wmode, prot, hv, rb_n;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	wire [20:0]  faddr;
	wire [15:0]  dq_i, dq_o, dq_oe;
	always #5 aclk = ~aclk;
	fpb_host uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .flash_addr(faddr), .data_io_i(dq_i),
		.data_io_o(dq_o), .data_io_oe(dq_oe), .chip_en_n(ce_n), .out_en_n(oe_n),
		.write_en_n(we_n), .flash_reset_n(frst_n), .word_mode(wmode),
		.protect_accel_pin(prot), .high_voltage_level(hv), .ready_busy_n(rb_n));
	fpb_flash_model fl (.aclk(aclk), .flash_addr(faddr), .data_io_o(dq_o),
		.data_io_oe(dq_oe), .chip_en_n(ce_n), .out_en_n(oe_n), .write_en_n(we_n),
		.flash_reset_n(frst_n), .word_mode(wmode),
		.protect_accel_pin(prot), .high_voltage_level(hv), .data_io_i(dq_i),
		.ready_busy_n(rb_n));
	function automatic [31:0] xs(input [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task chk(input string nm, input [31:0] ex, input [31:0] got);
		checked++;
		if (got !== ex)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// Watch responses against the oldest note
	always @(posedge aclk)
	begin
		if (bvalid && bready)
			chk("bresp", {30'h0, bq.pop_front()}, {30'h0, bresp});
		if (rvalid && rready)
		begin
			e = rq.pop_front();
			chk("rresp", {30'h0, e[65:64]}, {30'h0, rresp});
			chk("rdata", e[31:0], rdata & e[63:32]);
		end
	end
	task wr(input [4:0] a, input [31:0] d, input [1:0] r = `FPB_RESP_OKAY);
		bq.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (!bvalid);
		bready <= 0;
		@(posedge aclk);
	endtask
	task rd(input [4:0] a, input [31:0] m = 0, d = 0, input [1:0] r = 0);
		rq.push_back({r, m, d});
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do
		begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
		end while (!rvalid);
		last_rd = rdata;
		rready <= 0;
		@(posedge aclk);
	endtask
	task op(input [1:0] c);
		wr(`FPB_REG_CMD, {30'h0, c});
		for (int i = 0; i < 300; i++)
		begin
			rd(`FPB_REG_STATUS);
			if (last_rd[`FPB_ST_BUSY] === 1'b0) break;
		end
		chk("idle", 32'h0, {31'h0, last_rd[`FPB_ST_BUSY]});
	endtask
	task arr(input [31:0] a, input wm);
		logic [15:0] ex;
		ex = wm ? a[15:0] ^ 16'ha5c3 : {8'h00, a[7:0] ^ 8'hc3};
		wr(`FPB_REG_ADDR, a);
		op(`FPB_OP_READ);
		rd(`FPB_REG_RDATA, 32'hffffffff, {16'h0, ex});
	endtask
	task prog(input [31:0] ctl, input [7:0] n, input [31:0] a, input [7:0] p);
		logic [7:0] c0, p0;
		wr(`FPB_REG_CTRL, ctl);
		chk("protect", {31'h0, ctl[1]}, {31'h0, prot});
		wr(`FPB_REG_ADDR, a);
		c0 = fl.wcnt_q;
		p0 = fl.pgm_q;
		wr(`FPB_REG_WDATA, 32'h1234);
		op(`FPB_OP_PROGRAM);
		chk("writes", {24'h0, n}, {24'h0, fl.wcnt_q - c0});
		chk("programs", {24'h0, p}, {24'h0, fl.pgm_q - p0});
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		repeat (30000) @(posedge aclk);
		n_fail++;
		finish_test;
	end
	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd(`FPB_REG_CTRL, 32'hf, 32'h1);
		wstrb <= 4'h0;
		wr(`FPB_REG_CTRL, 0);
		wstrb <= 4'hf;
		rd(`FPB_REG_CTRL, 32'hf, 32'h1);
		rd(5'h18, 0, 0, `FPB_RESP_SLVERR);
		wr(5'h1c, 0, `FPB_RESP_SLVERR);
		for (int i = 0; i < 3; i++)
		begin
			rs = xs(rs);
			arr(rs & 32'h3fffff, 1);
		end
		wr(`FPB_REG_CTRL, 0);
		for (int i = 0; i < 3; i++)
		begin
			rs = xs(rs);
			arr(rs & 32'h3fffff, 0);
		end
		prog(32'h1, 8'd4, 0, 8'd1);
		prog(32'h9, 8'd2, 0, 8'd1);
		prog(32'h5, 8'd2, 32'h3f_ffff, 8'd1);
		prog(32'h1, 8'd4, 32'h3f_ffff, 8'd0);
		prog(32'h3, 8'd4, 32'h3f_ffff, 8'd1);
		wr(`FPB_REG_CTRL, 1);
		wr(`FPB_REG_CMD, {30'h0, `FPB_OP_PROGRAM});
		wr(`FPB_REG_ADDR, 0);
		op(`FPB_OP_READ);
		rd(`FPB_REG_STATUS, 32'h7, 32'h6);
		wr(`FPB_REG_WDATA, 32'h90);
		op(`FPB_OP_WRITE);
		op(`FPB_OP_READ);
		rd(`FPB_REG_RDATA, 32'hff, 32'h5a);
		wr(`FPB_REG_WDATA, 32'hf0);
		op(`FPB_OP_WRITE);
		rs = xs(rs);
		wr(`FPB_REG_ADDR, rs & 32'h1f_ffff);
		wr(`FPB_REG_WDATA, 32'h30);
		op(`FPB_OP_WRITE);
		chk("sector", {23'h0, rs[20:12]}, {23'h0, fl.sect_q});
		rd(`FPB_REG_STATUS, 32'h2, 32'h0);
		op(`FPB_OP_RESET);
		rd(`FPB_REG_STATUS, 32'hf, 32'ha);
		op(`FPB_OP_RESET);
		rd(`FPB_REG_STATUS, 32'hf, 32'h2);
		arr(32'h2b6e, 1);
		finish_test;
	end
endmodule // test_fpb_host
